// >>> pkg/cvt_defines.svh
// What this block does
// - Bits 7..1 of the charge voltage register hold a 7-bit target code, 10mV steps on 3.4V, reset 1010000.
// - Bit 0 of the charge voltage register picks a 100mV (0) or 200mV (1) recharge margin, reset 0.
// - Bit 7 of the timer register enables charge termination when set, reset 1.
// - Bits 5:4 of the timer register set the watchdog limit (off/40s/80s/160s, reset 01); it runs only with a battery.
// - Writing 1 to bit 3 of the timer register restarts the watchdog and the bit falls back to 0 by itself.
// - Bits 2:1 of the timer register set the fast charge timer limit (5/8/12/20 hours), reset 10.
// - Bit 0 of the timer register enables the charge safety timer when set, reset 1.
// - Bit 3 of the reference register disables the reference when 1, reset 0; a 1 to 0 change restarts plug-in detection and the safety timer.
`ifndef CVT_DEFINES_SVH
`define CVT_DEFINES_SVH

`define CVT_OFS_VREG 8'h07
`define CVT_OFS_TMR 8'h08
`define CVT_OFS_REF 8'h09

`define CVT_VREG_RST 7'h50
`define CVT_RECH_RST 1'h0
`define CVT_TERM_RST 1'h1
`define CVT_WDT_RST 2'h1
`define CVT_FCT_RST 2'h2
`define CVT_STEN_RST 1'h1
`define CVT_REFDIS_RST 1'h0

`define CVT_TMR_TERM 7
`define CVT_TMR_KICK 3
`define CVT_TMR_STEN 0
`define CVT_REF_DIS 3

`define CVT_CLK_HZ 25000000
`define CVT_WDT_UNIT_S 40
`define CVT_WDT_SECS_W 8

`define CVT_DEV_ADDR 7'h2A

`endif

// >>> pkg/cvt_pkg.sv
package cvt_pkg;

    typedef struct packed {
        logic [6:0] charge_target_voltage;
        logic recharge_margin_sel;
        logic term_en;
        logic [1:0] wdt_limit;
        logic [1:0] fast_charge_timer_limit;
        logic safety_timer_en;
        logic reference_disable;
    } cvt_cfg_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } cvt_wr_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_REG = 4'h3,
        ST_REG_ACK = 4'h4,
        ST_WDATA = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA = 4'h7,
        ST_RDATA_ACK = 4'h8
    } cvt_st_t;

endpackage : cvt_pkg

// >>> design/cvt_i2c_tgt.sv
`timescale 1ns/100ps
`default_nettype none
`include "cvt_defines.svh"

module cvt_i2c_tgt
    import cvt_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `CVT_DEV_ADDR
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Sync reset
    input wire logic scl_in, // Serial clock pin
    input wire logic sda_in, // Serial data pin level
    output logic sda_out, // Serial data drive value
    output logic sda_oe, // Serial data drive enable
    output cvt_wr_t wr, // Register write pulse
    output logic [7:0] ptr, // Register pointer
    input wire logic [7:0] rdata // Data at pointer
);
    logic [2:0] scl_s_q, sda_s_q;
    logic scl_f_q, sda_f_q;
    cvt_st_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic rw_q, mack_q;

    // Level moves only when the two later stages agree
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            scl_f_q <= 1'h1;
            sda_f_q <= 1'h1;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl_in};
            sda_s_q <= {sda_s_q[1:0], sda_in};
            if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
            if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
        end
    end

    wire scl_new = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
    wire sda_new = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
    wire scl_rise = scl_new && !scl_f_q;
    wire scl_fall = !scl_new && scl_f_q;
    wire start = scl_f_q && scl_new && sda_f_q && !sda_new;
    wire stop = scl_f_q && scl_new && !sda_f_q && sda_new;
    wire addr_hit = (sh_q[7:1] == DEV_ADDR);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            rw_q <= 1'h0;
            mack_q <= 1'h0;
            ptr <= 8'h00;
            sda_out <= 1'h0;
            sda_oe <= 1'h0;
            wr <= '0;
        end else begin
            wr.valid <= 1'h0;
            if (start) begin
                st_q <= ST_ADDR;
                cnt_q <= 4'h0;
                sda_oe <= 1'h0;
            end else if (stop) begin
                st_q <= ST_IDLE;
                sda_oe <= 1'h0;
            end else if (scl_rise) begin
                if (st_q == ST_ADDR || st_q == ST_REG || st_q == ST_WDATA) begin
                    sh_q <= {sh_q[6:0], sda_new};
                    cnt_q <= cnt_q + 4'h1;
                end
                if (st_q == ST_RDATA_ACK) mack_q <= !sda_new;
            end else if (scl_fall) begin
                case (st_q)
                    ST_ADDR: begin
                        if (cnt_q == 4'h8) begin
                            st_q <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
                            sda_oe <= addr_hit;
                            rw_q <= sh_q[0];
                        end
                    end
                    ST_ADDR_ACK, ST_RDATA_ACK: begin
                        if (st_q == ST_ADDR_ACK ? rw_q : mack_q) begin
                            // Load the byte and move the pointer on for bursts
                            sh_q <= {rdata[6:0], 1'h0};
                            sda_oe <= !rdata[7];
                            cnt_q <= 4'h1;
                            ptr <= ptr + 8'h01;
                            st_q <= ST_RDATA;
                        end else begin
                            sda_oe <= 1'h0;
                            cnt_q <= 4'h0;
                            st_q <= (st_q == ST_ADDR_ACK) ? ST_REG : ST_IDLE;
                        end
                    end
                    ST_REG: begin
                        if (cnt_q == 4'h8) begin
                            ptr <= sh_q;
                            sda_oe <= 1'h1;
                            st_q <= ST_REG_ACK;
                        end
                    end
                    ST_REG_ACK, ST_WDATA_ACK: begin
                        if (st_q == ST_WDATA_ACK) ptr <= ptr + 8'h01;
                        sda_oe <= 1'h0;
                        cnt_q <= 4'h0;
                        st_q <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        if (cnt_q == 4'h8) begin
                            wr.valid <= 1'h1;
                            wr.addr <= ptr;
                            wr.data <= sh_q;
                            sda_oe <= 1'h1;
                            st_q <= ST_WDATA_ACK;
                        end
                    end
                    ST_RDATA: begin
                        if (cnt_q == 4'h8) begin
                            sda_oe <= 1'h0;
                            st_q <= ST_RDATA_ACK;
                        end else begin
                            sda_oe <= !sh_q[7];
                            sh_q <= {sh_q[6:0], 1'h0};
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end
endmodule : cvt_i2c_tgt

`default_nettype wire

// >>> design/cvt_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "cvt_defines.svh"

module cvt_regs
    import cvt_pkg::*;
#(
    parameter int unsigned CYC_PER_SEC = `CVT_CLK_HZ,
    parameter logic [6:0] DEV_ADDR = `CVT_DEV_ADDR
) (
    input wire logic clk_sys, // System clock, 25 MHz
    input wire logic rst, // Power-on reset, sync
    input wire logic scl_in, // Serial clock pin
    input wire logic sda_in, // Serial data pin level
    output logic sda_out, // Serial data drive value
    output logic sda_oe, // Serial data drive enable
    input wire logic batt_present, // Battery detected
    input wire logic reg_defaults_req, // Defaults command pulse
    output cvt_cfg_t cfg, // Configuration fields
    output logic timeout_expiry, // Watchdog expired pulse
    output logic plugin_detect_restart, // Restart plug-in detection
    output logic safety_timer_restart // Restart safety timer
);
    cvt_wr_t wr;
    logic [7:0] ptr;
    logic [7:0] rdata;
    cvt_cfg_t cfg_d;
    logic kick_q;
    logic [31:0] pre_q;
    logic [`CVT_WDT_SECS_W-1:0] sec_q;

    localparam cvt_cfg_t CFG_RST = '{
        charge_target_voltage: `CVT_VREG_RST,
        recharge_margin_sel: `CVT_RECH_RST,
        term_en: `CVT_TERM_RST,
        wdt_limit: `CVT_WDT_RST,
        fast_charge_timer_limit: `CVT_FCT_RST,
        safety_timer_en: `CVT_STEN_RST,
        reference_disable: `CVT_REFDIS_RST
    };

    // Limit in seconds, multiples of the 40 s unit
    function automatic logic [`CVT_WDT_SECS_W-1:0] wdt_secs(input logic [1:0] code);
        case (code)
            2'h1: wdt_secs = `CVT_WDT_SECS_W'(`CVT_WDT_UNIT_S);
            2'h2: wdt_secs = `CVT_WDT_SECS_W'(2 * `CVT_WDT_UNIT_S);
            2'h3: wdt_secs = `CVT_WDT_SECS_W'(4 * `CVT_WDT_UNIT_S);
            default: wdt_secs = '0;
        endcase
    endfunction : wdt_secs

    cvt_i2c_tgt #(
        .DEV_ADDR(DEV_ADDR)
    ) u_tgt (
        .clk_sys(clk_sys),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .wr(wr),
        .ptr(ptr),
        .rdata(rdata)
    );

    wire wr_vreg = wr.valid && (wr.addr == `CVT_OFS_VREG);
    wire wr_tmr = wr.valid && (wr.addr == `CVT_OFS_TMR);
    wire wr_ref = wr.valid && (wr.addr == `CVT_OFS_REF);
    wire kick_wr = wr_tmr && wr.data[`CVT_TMR_KICK];

    // Reserved positions read back as zero, unmapped pointers too
    wire [7:0] rd_vreg = {cfg.charge_target_voltage, cfg.recharge_margin_sel};
    wire [7:0] rd_tmr = {cfg.term_en, 1'h0, cfg.wdt_limit, kick_q,
                         cfg.fast_charge_timer_limit, cfg.safety_timer_en};
    wire [7:0] rd_ref = {4'h0, cfg.reference_disable, 3'h0};
    assign rdata = (ptr == `CVT_OFS_VREG) ? rd_vreg :
                   (ptr == `CVT_OFS_TMR) ? rd_tmr :
                   (ptr == `CVT_OFS_REF) ? rd_ref : 8'h00;

    // Watchdog counts only with a battery and a nonzero limit
    wire wdt_run = batt_present && (cfg.wdt_limit != 2'h0);
    wire sec_tick = (pre_q == CYC_PER_SEC - 1);
    wire wdt_exp = wdt_run && sec_tick && (sec_q == wdt_secs(cfg.wdt_limit) - 1'b1);

    always_comb begin
        cfg_d = cfg;
        if (reg_defaults_req) begin
            cfg_d = CFG_RST;
        end else if (timeout_expiry) begin
            // Limit field survives expiry, everything else goes home
            cfg_d = CFG_RST;
            cfg_d.wdt_limit = cfg.wdt_limit;
        end
        if (wr_vreg) begin
            cfg_d.charge_target_voltage = wr.data[7:1];
            cfg_d.recharge_margin_sel = wr.data[0];
        end
        if (wr_tmr) begin
            cfg_d.term_en = wr.data[`CVT_TMR_TERM];
            cfg_d.wdt_limit = wr.data[5:4];
            cfg_d.fast_charge_timer_limit = wr.data[2:1];
            cfg_d.safety_timer_en = wr.data[`CVT_TMR_STEN];
        end
        if (wr_ref) cfg_d.reference_disable = wr.data[`CVT_REF_DIS];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg <= CFG_RST;
        end else begin
            cfg <= cfg_d;
        end
    end

    // Kick bit lives one cycle; a fresh write wins over its own clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            kick_q <= 1'h0;
        end else begin
            kick_q <= kick_wr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || !wdt_run || kick_q || wdt_exp) begin
            pre_q <= 32'h0;
            sec_q <= '0;
        end else if (sec_tick) begin
            pre_q <= 32'h0;
            sec_q <= sec_q + 1'b1;
        end else begin
            pre_q <= pre_q + 32'h1;
        end
    end

    // Expiry is registered, so the field restore lands one cycle later
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timeout_expiry <= 1'h0;
            plugin_detect_restart <= 1'h0;
            safety_timer_restart <= 1'h0;
        end else begin
            timeout_expiry <= wdt_exp;
            plugin_detect_restart <= cfg.reference_disable && !cfg_d.reference_disable;
            safety_timer_restart <= cfg.reference_disable && !cfg_d.reference_disable;
        end
    end
endmodule : cvt_regs

`default_nettype wire

// >>> bench/cvt_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module cvt_regs_assertions
    import cvt_pkg::*;
(
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic batt_present, // Battery
    input wire logic reg_defaults_req, // Defaults
    input wire cvt_cfg_t cfg, // Fields
    input wire logic timeout_expiry, // Expiry
    input wire logic plugin_detect_restart, // Restart
    input wire logic safety_timer_restart // Restart
);
    localparam cvt_cfg_t DEF = 15'h505A;
    localparam logic [14:0] KEEP = 15'h7FCF; // Limit survives expiry
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    reset_vals_a:
    assert property ($fell(rst) |-> cfg == DEF)
        else $error("bad reset value");
    defaults_cmd_a:
    assert property (reg_defaults_req |=> cfg == DEF)
        else $error("defaults missed");
    expiry_fields_a:
    assert property (timeout_expiry |=> (cfg & KEEP) == (DEF & KEEP))
        else $error("expiry restore missed");
    limit_kept_a:
    assert property (timeout_expiry |=> $stable(cfg.wdt_limit) [*2])
        else $error("limit lost at expiry");
    ref_restart_a:
    assert property ($fell(cfg.reference_disable) && !$past(rst) |-> plugin_detect_restart)
        else $error("no restart pulse");
    restart_pair_a:
    assert property (plugin_detect_restart == safety_timer_restart)
        else $error("restart pulses differ");
    no_batt_a:
    assert property (!batt_present [*2] |-> !timeout_expiry)
        else $error("expiry without battery");
    wdt_off_a:
    assert property ((cfg.wdt_limit == 2'h0) [*2] |-> !timeout_expiry)
        else $error("expiry while disabled");
endmodule : cvt_regs_assertions
bind cvt_regs cvt_regs_assertions cvt_regs_assertions_i (.clk_sys, .rst, .batt_present,
    .reg_defaults_req, .cfg, .timeout_expiry, .plugin_detect_restart, .safety_timer_restart);
`default_nettype wire

// >>> bench/cvt_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module cvt_host_model (
    input wire logic clk_sys, // Clock
    input wire logic sda_oe, // Target pulls data low
    output logic scl_in, // Clock wire
    output logic sda_in // Data wire
);
    localparam logic [6:0] DEV = 7'h2A; // Arbitrary target address
    logic pull_q = 1'b0;
    initial scl_in = 1'b1;
    assign sda_in = !(pull_q || sda_oe); // Pull-up when nobody pulls
    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : hold
    // Start when s, else stop; both need data moving while clock is high
    task automatic frame(input logic s);
        hold(6);
        pull_q <= !s;
        hold(6);
        scl_in <= 1'b1;
        hold(12);
        pull_q <= s;
        hold(12);
        scl_in <= !s;
    endtask : frame
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            hold(6);
            pull_q <= !tx[i];
            hold(6);
            scl_in <= 1'b1;
            hold(12);
            rx[i] = sda_in;
            scl_in <= 1'b0;
        end
    endtask : xfer
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [8:0] rx;
        frame(1'b1);
        xfer({DEV, 2'h1}, rx);
        xfer({p, 1'b1}, rx);
        xfer({d, 1'b1}, rx);
        frame(1'b0);
    endtask : wr
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [8:0] rx;
        frame(1'b1);
        xfer({DEV, 2'h1}, rx);
        xfer({p, 1'b1}, rx);
        frame(1'b1);
        xfer({DEV, 2'h3}, rx);
        xfer(9'h1FF, rx);
        d = rx[8:1];
        frame(1'b0);
    endtask : rd
endmodule : cvt_host_model
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import cvt_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic batt_present = 1'b0;
    logic reg_defaults_req = 1'b0;
    logic scl_in, sda_in, sda_out, sda_oe, timeout_expiry;
    logic plugin_detect_restart, safety_timer_restart;
    cvt_cfg_t cfg;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_plug = 0;
    int n_stmr = 0;
    // Rows: write flag, pointer, write data, expected read
    logic [24:0] rows [9] = '{25'h00700A0, 25'h0080095, 25'h0090000, 25'h107A5A5,
        25'h108FFB7, 25'h1080000, 25'h109FF08, 25'h1090000, 25'h10AFF00};
    cvt_regs #(.CYC_PER_SEC(64)) cvt_regs_i (.clk_sys, .rst, .scl_in, .sda_in,
        .sda_out, .sda_oe, .batt_present, .reg_defaults_req, .cfg, .timeout_expiry,
        .plugin_detect_restart, .safety_timer_restart);
    cvt_host_model cvt_host_model_i (.clk_sys, .sda_oe, .scl_in, .sda_in);
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic rdchk(input logic [7:0] p, input logic [7:0] e);
        logic [7:0] d;
        cvt_host_model_i.rd(p, d);
        check(d, e);
    endtask : rdchk
    // Restart pulses stand one cycle, so one look per cycle counts each once
    always @(negedge clk_sys) begin
        if (plugin_detect_restart === 1'b1) n_plug <= n_plug + 1;
        if (safety_timer_restart === 1'b1) n_stmr <= n_stmr + 1;
    end
    // 64 clocks a second here; slack covers prescaler phase and the bus tail after a kick
    task automatic wdt_span(input int secs);
        int n;
        n = 0;
        while (timeout_expiry !== 1'b1 && n < 6000) begin
            @(negedge clk_sys);
            n++;
        end
        check({7'h00, n > secs * 64 - 220 && n < secs * 64 + 20}, 8'h01);
    endtask : wdt_span
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        foreach (rows[i]) begin
            if (rows[i][24]) begin
                cvt_host_model_i.wr(rows[i][23:16], rows[i][15:8]);
            end
            rdchk(rows[i][23:16], rows[i][7:0]);
        end
        $display("register table done");
        reg_defaults_req <= 1'b1;
        @(posedge clk_sys);
        reg_defaults_req <= 1'b0;
        rdchk(8'h07, 8'hA0);
        rdchk(8'h08, 8'h95);
        check(cfg[14:7], 8'hA0);
        check({1'h0, cfg[6:0]}, 8'h5A);
        check(8'(n_plug), 8'h01);
        check(8'(n_stmr), 8'h01);
        $display("defaults command done");
        cvt_host_model_i.wr(8'h07, 8'h33);
        cvt_host_model_i.wr(8'h08, 8'h21);
        cvt_host_model_i.wr(8'h09, 8'h08);
        batt_present <= 1'b1;
        wdt_span(80);
        rdchk(8'h07, 8'hA0);
        rdchk(8'h08, 8'hA5);
        rdchk(8'h09, 8'h00);
        check(8'(n_plug), 8'h02);
        check(8'(n_stmr), 8'h02);
        cvt_host_model_i.wr(8'h08, 8'hAD);
        wdt_span(80);
        $display("watchdog done");
        @(posedge clk_sys);
        batt_present <= 1'b0;
        cvt_host_model_i.wr(8'h07, 8'h33);
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rdchk(8'h07, 8'hA0);
        batt_present <= 1'b1;
        wdt_span(40);
        $display("second reset done");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
